// >>> rtl/oss_source_select.sv
// Power-on clock source selection: samples configuration until four reads agree, then holds it
`timescale 1ns/100ps
module oss_source_select (
  input  wire logic            CLK,
  input  wire logic            RST_N,
  input  wire oss_pkg::oss_cfg_t CFG,
  output oss_pkg::oss_sel_t    SEL,
  output logic                 LOCKED,
  output logic                 CFG_INVALID
);

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [2:0] {
    ST_WAIT_READY = 3'h1,
    ST_SETTLE     = 3'h2,
    ST_LOCKED     = 3'h4
  } oss_state_t;

  typedef struct packed {
    oss_state_t         st;
    logic [3:0]         cnt;
    logic [5:0]         sample;
    oss_pkg::oss_sel_t  sel;
    logic               locked;
    logic               invalid;
  } oss_regs_t;

  localparam oss_regs_t REGS_RESET = '{
    st:      ST_WAIT_READY,
    cnt:     oss_pkg::CNT_ZERO,
    sample:  oss_pkg::SAMPLE_RESET,
    sel:     oss_pkg::SEL_RESET,
    locked:  1'b0,
    invalid: 1'b0
  };

  ////////////////////////////////////////////////////////////////////////////
  // Decode of the live configuration
  oss_pkg::oss_sel_t dec_sel;
  logic              dec_invalid;
  logic [5:0]        live;

  assign live = {CFG.clock_output_enable, CFG.primary_drive_config,
                 CFG.oscillator_select_field};

  oss_decode u_decode (
    .primary_drive_config    (CFG.primary_drive_config),
    .oscillator_select_field (CFG.oscillator_select_field),
    .clock_output_enable     (CFG.clock_output_enable),
    .sel                     (dec_sel),
    .invalid                 (dec_invalid)
  );

  ////////////////////////////////////////////////////////////////////////////
  // State
  oss_regs_t r_q;
  oss_regs_t r_d;

  // Sampling waits for a stable read, so a memory still powering up cannot
  // leave a half-read field behind; the cost is a few cycles on the default
  always_comb begin
    r_d = r_q;
    unique case (r_q.st)
      ST_WAIT_READY: begin
        if (CFG.ready) begin
          r_d.st     = ST_SETTLE;
          r_d.sample = live;
          r_d.cnt    = oss_pkg::CNT_ONE;
        end
      end
      ST_SETTLE: begin
        if (!CFG.ready) begin
          r_d.st  = ST_WAIT_READY;
          r_d.cnt = oss_pkg::CNT_ZERO;
        end else if (live != r_q.sample) begin
          r_d.sample = live;
          r_d.cnt    = oss_pkg::CNT_ONE;
        end else if (r_q.cnt == oss_pkg::SETTLE_COUNT - oss_pkg::CNT_ONE) begin
          r_d.st      = ST_LOCKED;
          r_d.cnt     = oss_pkg::CNT_ZERO;
          r_d.sel     = dec_sel;
          r_d.invalid = dec_invalid;
          r_d.locked  = 1'b1;
        end else begin
          r_d.cnt = r_q.cnt + oss_pkg::CNT_ONE;
        end
      end
      ST_LOCKED: begin
        // Held until the next power-on reset; later memory contents ignored
        r_d = r_q;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      r_q <= REGS_RESET;
    end else begin
      r_q <= r_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from the state flops
  assign SEL         = r_q.sel;
  assign LOCKED      = r_q.locked;
  assign CFG_INVALID = r_q.invalid;

endmodule : oss_source_select

// >>> inc/oss_pkg.sv
// Shared types and constants for the power-on oscillator source selection
package oss_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration field encodings
  localparam logic [1:0] PRIM_INTERNAL   = 2'h3;
  localparam logic [1:0] PRIM_HIGH_SPEED = 2'h2;
  localparam logic [1:0] PRIM_MED_SPEED  = 2'h1;
  localparam logic [1:0] PRIM_EXT_CLOCK  = 2'h0;

  localparam logic [2:0] SEL_FRC_POST  = 3'h7;
  localparam logic [2:0] SEL_FRC_DIV16 = 3'h6;
  localparam logic [2:0] SEL_LOW_POWER_RC      = 3'h5;
  localparam logic [2:0] SEL_SECONDARY = 3'h4;
  localparam logic [2:0] SEL_PRIM_PLL  = 3'h3;
  localparam logic [2:0] SEL_PRIM      = 3'h2;
  localparam logic [2:0] SEL_FRC_PLL   = 3'h1;
  localparam logic [2:0] SEL_FRC       = 3'h0;

  // Erased configuration memory reads as all ones
  localparam logic [1:0] PRIM_ERASED = 2'h3;
  localparam logic [2:0] SEL_ERASED  = 3'h7;

  ////////////////////////////////////////////////////////////////////////////
  // Timing: consecutive identical samples needed before the choice is taken
  localparam logic [3:0] SETTLE_COUNT = 4'h4;
  localparam logic [3:0] CNT_ZERO     = 4'h0;
  localparam logic [3:0] CNT_ONE      = 4'h1;

  ////////////////////////////////////////////////////////////////////////////
  // Clock modes
  typedef enum logic [3:0] {
    MODE_FAST_RC_WITH_POSTSCALER = 4'h0,
    MODE_FAST_RC_DIV_SIXTEEN     = 4'h1,
    MODE_LOW_POWER_RC            = 4'h2,
    MODE_SECONDARY_TIMER_OSC     = 4'h3,
    MODE_HIGH_SPEED_CRYSTAL_PLL  = 4'h4,
    MODE_MEDIUM_SPEED_CRYSTAL_PLL = 4'h5,
    MODE_EXTERNAL_CLOCK_PLL      = 4'h6,
    MODE_HIGH_SPEED_CRYSTAL      = 4'h7,
    MODE_MEDIUM_SPEED_CRYSTAL    = 4'h8,
    MODE_EXTERNAL_CLOCK_INPUT    = 4'h9,
    MODE_FAST_RC_PLL             = 4'hA,
    MODE_FAST_RC_PLAIN           = 4'hB
  } oss_mode_t;

  // Configuration as read from nonvolatile memory
  typedef struct packed {
    logic       ready;
    logic       clock_output_enable;
    logic [1:0] primary_drive_config;
    logic [2:0] oscillator_select_field;
  } oss_cfg_t;

  // Decoded clock source selection
  typedef struct packed {
    oss_mode_t  mode;
    logic       fast_rc;
    logic       low_power_rc;
    logic       secondary;
    logic       primary;
    logic       pll_en;
    logic       postscaler_en;
    logic       div_sixteen_en;
    logic [1:0] drive;
    logic       pin_two_clock_out;
    logic       pin_two_oscillator;
  } oss_sel_t;

  // Selection held from reset until a valid configuration is latched
  localparam oss_sel_t SEL_RESET = '{
    mode:               MODE_FAST_RC_WITH_POSTSCALER,
    fast_rc:            1'b1,
    low_power_rc:       1'b0,
    secondary:          1'b0,
    primary:            1'b0,
    pll_en:             1'b0,
    postscaler_en:      1'b1,
    div_sixteen_en:     1'b0,
    drive:              PRIM_INTERNAL,
    pin_two_clock_out:  1'b0,
    pin_two_oscillator: 1'b0
  };

  localparam logic [5:0] SAMPLE_RESET = {1'b0, PRIM_ERASED, SEL_ERASED};

endpackage : oss_pkg

// >>> rtl/oss_decode.sv
// Combinational decoder from configuration fields to a clock source choice
`timescale 1ns/100ps
module oss_decode (
  input  wire logic [1:0]      primary_drive_config,
  input  wire logic [2:0]      oscillator_select_field,
  input  wire logic            clock_output_enable,
  output oss_pkg::oss_sel_t    sel,
  output logic                 invalid
);

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic internal_prim;
    internal_prim = (primary_drive_config == oss_pkg::PRIM_INTERNAL);
    sel           = oss_pkg::SEL_RESET;
    invalid       = 1'b0;
    sel.fast_rc       = 1'b0;
    sel.postscaler_en = 1'b0;
    unique case (oscillator_select_field)
      oss_pkg::SEL_FRC_POST: begin
        sel.mode          = oss_pkg::MODE_FAST_RC_WITH_POSTSCALER;
        sel.fast_rc       = 1'b1;
        sel.postscaler_en = 1'b1;
      end
      oss_pkg::SEL_FRC_DIV16: begin
        sel.mode           = oss_pkg::MODE_FAST_RC_DIV_SIXTEEN;
        sel.fast_rc        = 1'b1;
        sel.div_sixteen_en = 1'b1;
      end
      oss_pkg::SEL_LOW_POWER_RC: begin
        sel.mode         = oss_pkg::MODE_LOW_POWER_RC;
        sel.low_power_rc = 1'b1;
      end
      oss_pkg::SEL_SECONDARY: begin
        sel.mode      = oss_pkg::MODE_SECONDARY_TIMER_OSC;
        sel.secondary = 1'b1;
      end
      oss_pkg::SEL_PRIM_PLL, oss_pkg::SEL_PRIM: begin
        sel.primary = 1'b1;
        sel.drive   = primary_drive_config;
        sel.pll_en  = (oscillator_select_field == oss_pkg::SEL_PRIM_PLL);
        sel.pin_two_oscillator = 1'b1;
        unique case (primary_drive_config)
          oss_pkg::PRIM_HIGH_SPEED:
            sel.mode = sel.pll_en ? oss_pkg::MODE_HIGH_SPEED_CRYSTAL_PLL
                                  : oss_pkg::MODE_HIGH_SPEED_CRYSTAL;
          oss_pkg::PRIM_MED_SPEED:
            sel.mode = sel.pll_en ? oss_pkg::MODE_MEDIUM_SPEED_CRYSTAL_PLL
                                  : oss_pkg::MODE_MEDIUM_SPEED_CRYSTAL;
          oss_pkg::PRIM_EXT_CLOCK:
            sel.mode = sel.pll_en ? oss_pkg::MODE_EXTERNAL_CLOCK_PLL
                                  : oss_pkg::MODE_EXTERNAL_CLOCK_INPUT;
          oss_pkg::PRIM_INTERNAL:
            invalid = 1'b1;
        endcase
      end
      oss_pkg::SEL_FRC_PLL: begin
        sel.mode    = oss_pkg::MODE_FAST_RC_PLL;
        sel.fast_rc = 1'b1;
        sel.pll_en  = 1'b1;
      end
      oss_pkg::SEL_FRC: begin
        sel.mode    = oss_pkg::MODE_FAST_RC_PLAIN;
        sel.fast_rc = 1'b1;
      end
    endcase
    // Internal and secondary choices need the primary field left at internal
    if (!sel.primary && !internal_prim) begin
      invalid = 1'b1;
    end
    // Illegal pairs fall back to the erased default, a source that always runs
    if (invalid) begin
      sel = oss_pkg::SEL_RESET;
    end
    // Pin two follows its own enable bit whenever the primary is not in use
    if (!sel.primary) begin
      sel.pin_two_clock_out = clock_output_enable;
    end
  end

endmodule : oss_decode

// >>> test/oss_source_select_checker.sv
// Port checker for the oscillator source selection
`timescale 1ns/100ps
module oss_source_select_checker (
  input wire logic              CLK,
  input wire logic              RST_N,
  input wire oss_pkg::oss_cfg_t CFG,
  input wire oss_pkg::oss_sel_t SEL,
  input wire logic              LOCKED,
  input wire logic              CFG_INVALID
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  ////////////////////////////////////////////////////////////////////////////
  sequence s_settle; (CFG.ready && $stable(CFG)) [*4]; endsequence
  sequence s_lock; $rose(LOCKED) ##0 !CFG_INVALID; endsequence
  property p_hold; LOCKED |=> LOCKED && $stable(SEL) && $stable(CFG_INVALID); endproperty
  a_hold: assert property (p_hold) else $error("choice moved after lock");
  property p_bound; s_settle |=> LOCKED; endproperty
  a_bound: assert property (p_bound) else $error("no lock on steady fields");
  property p_cause; $rose(LOCKED) |-> $past(CFG.ready, 4) && $past(CFG, 1) == $past(CFG, 4)
    && $past(CFG, 2) == $past(CFG, 4) && $past(CFG, 3) == $past(CFG, 4); endproperty
  a_cause: assert property (p_cause) else $error("lock on moving fields");
  property p_early; !LOCKED |-> SEL == oss_pkg::SEL_RESET && !CFG_INVALID; endproperty
  a_early: assert property (p_early) else $error("default choice lost");
  property p_bad; $rose(LOCKED) |-> CFG_INVALID == (($past(CFG.primary_drive_config) ==
    oss_pkg::PRIM_INTERNAL) == ($past(CFG.oscillator_select_field[2:1]) == 2'h1)); endproperty
  a_bad: assert property (p_bad) else $error("invalid flag wrong");
  property p_prim; s_lock ##0 $past(CFG.oscillator_select_field[2:1]) == 2'h1 |-> SEL.primary
    && SEL.drive == $past(CFG.primary_drive_config)
    && SEL.pll_en == $past(CFG.oscillator_select_field[0]); endproperty
  a_prim: assert property (p_prim) else $error("primary choice wrong");
  property p_int; s_lock ##0 $past(CFG.primary_drive_config) == oss_pkg::PRIM_INTERNAL
    |-> !SEL.primary && SEL.pll_en == ($past(CFG.oscillator_select_field) == 3'h1)
    && SEL.div_sixteen_en == ($past(CFG.oscillator_select_field) == 3'h6); endproperty
  a_int: assert property (p_int) else $error("internal choice wrong");
  property p_pin; s_lock ##0 $past(CFG.primary_drive_config) == oss_pkg::PRIM_INTERNAL
    |-> SEL.pin_two_clock_out == $past(CFG.clock_output_enable) && !SEL.pin_two_oscillator;
  endproperty
  a_pin: assert property (p_pin) else $error("pin two function wrong");
endmodule : oss_source_select_checker
bind oss_source_select oss_source_select_checker oss_source_select_checker_i (.CLK(CLK),
  .RST_N(RST_N), .CFG(CFG), .SEL(SEL), .LOCKED(LOCKED), .CFG_INVALID(CFG_INVALID));

// >>> test/oss_cfg_memory_model.sv
// Configuration memory model feeding the selection block
`timescale 1ns/100ps
module oss_cfg_memory_model (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [5:0]   word,
  input  wire logic [3:0]   lag,
  input  wire logic         stall,
  output oss_pkg::oss_cfg_t cfg
);
  logic [3:0] wait_q;
  wire        ok = (wait_q == lag) && !stall;
  // Unsettled reads toggle so a stale value never looks valid
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_q <= 4'h0;
      cfg    <= '0;
    end else begin
      wait_q <= (wait_q == lag) ? wait_q : wait_q + 4'h1;
      cfg    <= {ok, ok ? word : ~cfg[5:0]};
    end
  end
endmodule : oss_cfg_memory_model

// >>> test/oss_source_select_tb_top.sv
// Self-checking bench for the oscillator source selection
`timescale 1ns/100ps
module oss_source_select_tb_top;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic [5:0]        word = 6'h3f;
  logic [3:0]        lag = 4'h0;
  logic              stall = 1'b0;
  oss_pkg::oss_cfg_t cfg;
  oss_pkg::oss_sel_t sel;
  logic              locked;
  logic              cfg_invalid;
  int                errors = 0;
  int                check_count = 0;
  always #2 clk = ~clk;
  oss_cfg_memory_model oss_cfg_memory_model_i (.clk(clk), .rst_n(rst_n), .word(word),
    .lag(lag), .stall(stall), .cfg(cfg));
  oss_source_select oss_source_select_i (.CLK(clk), .RST_N(rst_n), .CFG(cfg), .SEL(sel),
    .LOCKED(locked), .CFG_INVALID(cfg_invalid));
  ////////////////////////////////////////////////////////////////////////////
  // Mode enum order lets the table collapse to offsets; illegal pairs give erased choice
  function automatic oss_pkg::oss_mode_t exp_mode(input logic [1:0] p, input logic [2:0] s);
    logic [3:0] m;
    if ((p == 2'h3) == (s[2:1] == 2'h1)) m = 4'h0;
    else if (s[2:1] == 2'h1) m = (s[0] ? 4'h6 : 4'h9) - {2'h0, p};
    else m = (s[2] ? 4'h7 : 4'hb) - {1'h0, s};
    return oss_pkg::oss_mode_t'(m);
  endfunction : exp_mode
  // Flags follow from the mode; non-primary choices report the internal drive code
  function automatic oss_pkg::oss_sel_t exp_sel(input logic [1:0] p, input logic [2:0] s,
                                                input logic c);
    oss_pkg::oss_sel_t e;
    e                    = '0;
    e.mode               = exp_mode(p, s);
    e.fast_rc            = e.mode inside {4'h0, 4'h1, 4'ha, 4'hb};
    e.low_power_rc       = (e.mode == 4'h2);
    e.secondary          = (e.mode == 4'h3);
    e.primary            = e.mode inside {[4'h4:4'h9]};
    e.pll_en             = e.mode inside {4'h4, 4'h5, 4'h6, 4'ha};
    e.postscaler_en      = (e.mode == 4'h0);
    e.div_sixteen_en     = (e.mode == 4'h1);
    e.drive              = e.primary ? p : 2'h3;
    e.pin_two_clock_out  = !e.primary && c;
    e.pin_two_oscillator = e.primary;
    return e;
  endfunction : exp_sel
  task automatic cmp_sel(input oss_pkg::oss_sel_t e, input oss_pkg::oss_sel_t g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("wrong value at %0t: expected %h got %h", $time, e, g);
    end
  endtask : cmp_sel
  task automatic cmp_mode(input oss_pkg::oss_mode_t e, input oss_pkg::oss_mode_t g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("wrong value at %0t: expected %h got %h", $time, e, g);
    end
  endtask : cmp_mode
  task automatic cmp_flag(input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("wrong value at %0t: expected %h got %h", $time, e, g);
    end
  endtask : cmp_flag
  task automatic start(input logic [5:0] w, input logic [3:0] l);
    rst_n = 1'b0;
    word  = w;
    lag   = l;
    stall = 1'b0;
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
  endtask : start
  task automatic wait_lock;
    int n;
    n = 0;
    while (locked !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1 n++;
    end
    cmp_flag(1'b1, locked);
  endtask : wait_lock
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_latency;
    start(6'h0b, 4'h9);
    while (cfg.ready !== 1'b1) @(posedge clk) #1;
    cmp_mode(oss_pkg::MODE_FAST_RC_WITH_POSTSCALER, sel.mode);
    repeat (3) @(posedge clk);
    #1 cmp_flag(1'b0, locked);
    @(posedge clk);
    #1 cmp_flag(1'b1, locked);
    cmp_mode(oss_pkg::MODE_MEDIUM_SPEED_CRYSTAL_PLL, sel.mode);
    cmp_sel(exp_sel(2'h1, 3'h3, 1'b0), sel);
  endtask : t_latency
  task automatic t_restart;
    start(6'h1c, 4'h0);
    @(posedge clk);
    #1 stall = 1'b1;
    @(posedge clk);
    #1 stall = 1'b0;
    word = 6'h1d;
    repeat (3) @(posedge clk);
    #1 cmp_flag(1'b0, locked);
    wait_lock();
    cmp_mode(oss_pkg::MODE_LOW_POWER_RC, sel.mode);
  endtask : t_restart
  task automatic t_hold;
    word = 6'h0a;
    stall = 1'b1;
    repeat (4) @(posedge clk);
    #1 stall = 1'b0;
    repeat (8) @(posedge clk);
    #1 cmp_mode(oss_pkg::MODE_LOW_POWER_RC, sel.mode);
    cmp_flag(1'b1, locked);
    cmp_sel(exp_sel(2'h3, 3'h5, 1'b0), sel);
  endtask : t_hold
  task automatic t_modes;
    for (int i = 0; i < 32; i++) begin
      start({1'b0, i[4:0]}, 4'h0);
      wait_lock();
      cmp_mode(exp_mode(i[4:3], i[2:0]), sel.mode);
      cmp_sel(exp_sel(i[4:3], i[2:0], 1'b0), sel);
      cmp_flag((i[4:3] == 2'h3) == (i[2:1] == 2'h1), cfg_invalid);
    end
  endtask : t_modes
  task automatic t_pin;
    for (int i = 0; i < 4; i++) begin
      start({i[0], i[1] ? 5'h0a : 5'h1e}, 4'h2);
      wait_lock();
      cmp_flag(i[0] && !i[1], sel.pin_two_clock_out);
      cmp_flag(i[1], sel.pin_two_oscillator);
      cmp_sel(exp_sel(i[1] ? 2'h1 : 2'h3, i[1] ? 3'h2 : 3'h6, i[0]), sel);
    end
  endtask : t_pin
  task automatic final_report;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  // Whole run needs about 300 cycles; the limit leaves a wide margin
  initial begin
    #40000;
    errors++;
    final_report();
  end
  initial begin
    t_latency();
    t_restart();
    t_hold();
    t_modes();
    t_pin();
    final_report();
  end
endmodule : oss_source_select_tb_top
